// *** ctx_exc_map.vh ***
// constants for the cpu exception unit
`ifndef CTX_EXC_MAP_VH
`define CTX_EXC_MAP_VH

// register byte offsets
`define CTX_OFF_PRI_A     8'h00
`define CTX_OFF_PRI_B     8'h04
`define CTX_OFF_PRI_C     8'h08
`define CTX_OFF_PRI_D     8'h0C
`define CTX_OFF_PRI_E     8'h10
`define CTX_OFF_STATUS    8'h14
`define CTX_OFF_VBASE     8'h18
`define CTX_OFF_EXC_STAT  8'h1C

// reset values
`define CTX_RST_PRI       16'h0000
`define CTX_RST_STATUS    32'h0000_00F0
`define CTX_RST_VBASE     32'h0000_0000

// status word mask field
`define CTX_MASK_LSB      4
`define CTX_MASK_MSB      7

// priority levels
`define CTX_LVL_NMI       5'h10
`define CTX_LVL_FIXED15   5'h0F
`define CTX_MASK_NMI      4'hF

// vector numbers
`define CTX_VEC_ILL_GEN   8'h04
`define CTX_VEC_ILL_SLOT  8'h06
`define CTX_VEC_NMI       8'h0B
`define CTX_VEC_BRK       8'h0C
`define CTX_VEC_DBG       8'h0E
`define CTX_VEC_IRL_BASE  8'h40
`define CTX_VEC_IRQ_BASE  8'h50
`define CTX_VEC_PER_BASE  8'h60

// source counts
`define CTX_N_IRQ         4
`define CTX_N_PER         29

`endif

// *** ctx_exception_unit.v ***
// cpu exception unit: interrupt acceptance, traps, illegal code
`timescale 1ns/10ps
`include "ctx_exc_map.vh"

module ctx_exception_unit (
    // clock and reset
    input  wire        CORE_CLK,
    input  wire        SRST,
    // ahb-lite slave
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output reg  [31:0] HRDATA,
    output reg         HREADYOUT,
    output reg         HRESP,
    // interrupt requests
    input  wire        NMI_REQ,
    input  wire        BRK_REQ,
    input  wire        DBG_REQ,
    input  wire [3:0]  ENCODED_LEVEL_PINS,
    input  wire [3:0]  EXTERNAL_REQUEST_PINS,
    input  wire [28:0] PER_REQ,
    // decoder
    input  wire        DEC_VALID,
    input  wire        DEC_IN_SLOT,
    input  wire        DEC_AFTER_SYSREG,
    input  wire        DEC_UNDEF,
    input  wire        DEC_PC_WRITE,
    input  wire        DEC_TRAP,
    input  wire [7:0]  DEC_TRAP_VEC,
    input  wire [31:0] DEC_PC,
    input  wire [31:0] DEC_NEXT_PC,
    input  wire [31:0] DEC_SLOT_TARGET,
    // stacking, vector fetch, jump
    output reg         EXC_BUSY,
    output reg         STK_WR,
    output reg  [31:0] STK_DATA,
    output reg         VEC_RD,
    output reg  [31:0] VEC_ADDR,
    input  wire        VEC_ACK,
    input  wire [31:0] VEC_DATA,
    output reg         JUMP,
    output reg  [31:0] JUMP_PC,
    output reg  [3:0]  SR_MASK
);

    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_PSR  = 5'b00010;
    localparam [4:0] ST_PPC  = 5'b00100;
    localparam [4:0] ST_VEC  = 5'b01000;
    localparam [4:0] ST_WAIT = 5'b10000;

    reg [15:0] pri_a_reg;
    reg [15:0] pri_b_reg;
    reg [15:0] external_pin_priority_register;
    reg [15:0] pri_d_reg;
    reg [15:0] pri_e_reg;
    reg [31:0] status_word_reg;
    reg [31:0] vbase_reg;
    reg        nmi_pend_reg;
    reg [4:0]  state_reg;
    reg        is_int_reg;
    reg [3:0]  new_mask_reg;
    reg [7:0]  vec_reg;
    reg [31:0] pc_save_reg;
    reg [31:0] sr_save_reg;
    reg        wr_pend_reg;
    reg [7:0]  wr_addr_reg;

    // priority field of a 16-bit setting register
    function [3:0] fld;
        input [15:0] r;
        input [1:0]  sel;
        begin
            fld = r[4*sel +: 4];
        end
    endfunction

    // peripheral source index to its programmed level
    function [3:0] per_pri;
        input [4:0]  idx;
        input [15:0] a;
        input [15:0] b;
        input [15:0] d;
        begin
            if (idx < 5'd2) begin
                per_pri = fld(a, 2'd3);
            end else if (idx == 5'd2) begin
                per_pri = fld(a, 2'd1);
            end else if (idx < 5'd6) begin
                per_pri = fld(b, 2'd3);
            end else if (idx == 5'd6) begin
                per_pri = fld(a, 2'd2);
            end else if (idx == 5'd7) begin
                per_pri = fld(a, 2'd0);
            end else if (idx < 5'd12) begin
                per_pri = fld(b, 2'd2);
            end else if (idx < 5'd16) begin
                per_pri = fld(b, 2'd1);
            end else begin
                per_pri = fld(d, 2'd3);
            end
        end
    endfunction

    // arbitration over all sources
    reg [4:0] best_lvl;
    reg [7:0] best_vec;
    reg [3:0] p;
    integer   i;
    always @* begin
        best_lvl = 5'd0;
        best_vec = 8'h00;
        p = 4'd0;
        if (nmi_pend_reg) begin
            best_lvl = `CTX_LVL_NMI;
            best_vec = `CTX_VEC_NMI;
        end else if (BRK_REQ) begin
            best_lvl = `CTX_LVL_FIXED15;
            best_vec = `CTX_VEC_BRK;
        end else if (DBG_REQ) begin
            best_lvl = `CTX_LVL_FIXED15;
            best_vec = `CTX_VEC_DBG;
        end
        // zero on the level pins means no request
        if ({1'b0, ENCODED_LEVEL_PINS} > best_lvl) begin
            best_lvl = {1'b0, ENCODED_LEVEL_PINS};
            best_vec = `CTX_VEC_IRL_BASE + {4'h0, ENCODED_LEVEL_PINS};
        end
        for (i = 0; i < `CTX_N_IRQ; i = i + 1) begin
            p = fld(external_pin_priority_register, 2'd3 - i[1:0]);
            if (EXTERNAL_REQUEST_PINS[i] && {1'b0, p} > best_lvl) begin
                best_lvl = {1'b0, p};
                best_vec = `CTX_VEC_IRQ_BASE + {6'h00, i[1:0]};
            end
        end
        for (i = 0; i < `CTX_N_PER; i = i + 1) begin
            p = per_pri(i[4:0], pri_a_reg, pri_b_reg, pri_d_reg);
            if (PER_REQ[i] && {1'b0, p} > best_lvl) begin
                best_lvl = {1'b0, p};
                best_vec = `CTX_VEC_PER_BASE + {3'h0, i[4:0]};
            end
        end
    end

    wire [3:0] cur_mask =
        status_word_reg[`CTX_MASK_MSB:`CTX_MASK_LSB];
    // strictly above mask, so level zero never wins
    wire int_ok = nmi_pend_reg ||
        (best_lvl > {1'b0, cur_mask});
    // slot and post-sysreg decode points hold interrupts off
    wire int_open = !DEC_IN_SLOT && !DEC_AFTER_SYSREG;
    wire dec_go = DEC_VALID && state_reg[0];
    wire slot_ill = DEC_IN_SLOT &&
        (DEC_UNDEF || DEC_PC_WRITE || DEC_TRAP);
    wire take_int = dec_go && !slot_ill && !DEC_UNDEF &&
        !DEC_TRAP && int_open && int_ok;
    wire take_nmi = take_int && nmi_pend_reg;

    // bus side
    wire ahb_go = HSEL && HREADY && HTRANS[1];
    reg [31:0] rd_val;
    always @* begin
        rd_val = 32'h0000_0000;
        if (HADDR[7:0] == `CTX_OFF_PRI_A) begin
            rd_val = {16'h0000, pri_a_reg};
        end else if (HADDR[7:0] == `CTX_OFF_PRI_B) begin
            rd_val = {16'h0000, pri_b_reg};
        end else if (HADDR[7:0] == `CTX_OFF_PRI_C) begin
            rd_val = {16'h0000, external_pin_priority_register};
        end else if (HADDR[7:0] == `CTX_OFF_PRI_D) begin
            rd_val = {16'h0000, pri_d_reg};
        end else if (HADDR[7:0] == `CTX_OFF_PRI_E) begin
            rd_val = {16'h0000, pri_e_reg};
        end else if (HADDR[7:0] == `CTX_OFF_STATUS) begin
            rd_val = status_word_reg;
        end else if (HADDR[7:0] == `CTX_OFF_VBASE) begin
            rd_val = vbase_reg;
        end else if (HADDR[7:0] == `CTX_OFF_EXC_STAT) begin
            rd_val = {15'h0000, nmi_pend_reg, vec_reg,
                      3'h0, state_reg};
        end
    end

    always @(posedge CORE_CLK) begin
        if (SRST) begin
            HRDATA    <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            // zero wait states; unmapped words read zero
            wr_pend_reg <= ahb_go && HWRITE;
            wr_addr_reg <= HADDR[7:0];
            if (ahb_go && !HWRITE) begin
                HRDATA <= rd_val;
            end
        end
    end

    always @(posedge CORE_CLK) begin
        if (SRST) begin
            pri_a_reg   <= `CTX_RST_PRI;
            pri_b_reg   <= `CTX_RST_PRI;
            external_pin_priority_register <= `CTX_RST_PRI;
            pri_d_reg   <= `CTX_RST_PRI;
            pri_e_reg   <= `CTX_RST_PRI;
            vbase_reg   <= `CTX_RST_VBASE;
        end else if (wr_pend_reg) begin
            // 4-bit fields cannot hold level sixteen
            if (wr_addr_reg == `CTX_OFF_PRI_A) begin
                pri_a_reg <= HWDATA[15:0];
            end else if (wr_addr_reg == `CTX_OFF_PRI_B) begin
                pri_b_reg <= HWDATA[15:0];
            end else if (wr_addr_reg == `CTX_OFF_PRI_C) begin
                external_pin_priority_register <= HWDATA[15:0];
            end else if (wr_addr_reg == `CTX_OFF_PRI_D) begin
                pri_d_reg <= HWDATA[15:0];
            end else if (wr_addr_reg == `CTX_OFF_PRI_E) begin
                pri_e_reg <= HWDATA[15:0];
            end else if (wr_addr_reg == `CTX_OFF_VBASE) begin
                vbase_reg <= {HWDATA[31:2], 2'b00};
            end
        end
    end

    // nmi is latched so a short pulse is not lost
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            nmi_pend_reg <= 1'b0;
        end else if (NMI_REQ) begin
            nmi_pend_reg <= 1'b1;
        end else if (take_nmi) begin
            nmi_pend_reg <= 1'b0;
        end
    end

    // exception sequencer
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            state_reg       <= ST_IDLE;
            status_word_reg <= `CTX_RST_STATUS;
            is_int_reg   <= 1'b0;
            new_mask_reg <= 4'h0;
            vec_reg      <= 8'h00;
            pc_save_reg  <= 32'h0000_0000;
            sr_save_reg  <= 32'h0000_0000;
            EXC_BUSY <= 1'b0;
            STK_WR   <= 1'b0;
            STK_DATA <= 32'h0000_0000;
            VEC_RD   <= 1'b0;
            VEC_ADDR <= 32'h0000_0000;
            JUMP     <= 1'b0;
            JUMP_PC  <= 32'h0000_0000;
            SR_MASK  <= 4'hF;
        end else begin
            STK_WR <= 1'b0;
            VEC_RD <= 1'b0;
            JUMP   <= 1'b0;
            if (wr_pend_reg && wr_addr_reg == `CTX_OFF_STATUS) begin
                status_word_reg <= HWDATA;
            end
            case (state_reg)
            ST_IDLE: begin
                sr_save_reg <= status_word_reg;
                is_int_reg  <= 1'b0;
                if (dec_go && slot_ill) begin
                    vec_reg     <= `CTX_VEC_ILL_SLOT;
                    pc_save_reg <= DEC_SLOT_TARGET;
                    state_reg   <= ST_PSR;
                    EXC_BUSY    <= 1'b1;
                end else if (dec_go && DEC_UNDEF) begin
                    vec_reg     <= `CTX_VEC_ILL_GEN;
                    pc_save_reg <= DEC_PC;
                    state_reg   <= ST_PSR;
                    EXC_BUSY    <= 1'b1;
                end else if (dec_go && DEC_TRAP) begin
                    vec_reg     <= DEC_TRAP_VEC;
                    pc_save_reg <= DEC_NEXT_PC;
                    state_reg   <= ST_PSR;
                    EXC_BUSY    <= 1'b1;
                end else if (take_int) begin
                    // decoded instruction is not run; it resumes later
                    vec_reg      <= best_vec;
                    pc_save_reg  <= DEC_PC;
                    is_int_reg   <= 1'b1;
                    new_mask_reg <= take_nmi ? `CTX_MASK_NMI
                                             : best_lvl[3:0];
                    state_reg    <= ST_PSR;
                    EXC_BUSY     <= 1'b1;
                end
            end
            ST_PSR: begin
                STK_WR    <= 1'b1;
                STK_DATA  <= sr_save_reg;
                state_reg <= ST_PPC;
            end
            ST_PPC: begin
                STK_WR    <= 1'b1;
                STK_DATA  <= pc_save_reg;
                state_reg <= ST_VEC;
                if (is_int_reg) begin
                    // stacking done, raise mask; beats a bus write
                    status_word_reg[`CTX_MASK_MSB:`CTX_MASK_LSB]
                        <= new_mask_reg;
                end
            end
            ST_VEC: begin
                VEC_RD    <= 1'b1;
                VEC_ADDR  <= vbase_reg + {22'h0, vec_reg, 2'b00};
                state_reg <= ST_WAIT;
            end
            ST_WAIT: begin
                // vector fetch may stretch; no timeout here
                if (VEC_ACK) begin
                    JUMP      <= 1'b1;
                    JUMP_PC   <= VEC_DATA;
                    EXC_BUSY  <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            end
            default: begin
                state_reg <= ST_IDLE;
                EXC_BUSY  <= 1'b0;
            end
            endcase
            SR_MASK <= (state_reg[2] && is_int_reg) ? new_mask_reg
                     : cur_mask;
        end
    end

endmodule

// *** ctx_exc_props.sv ***
// assertion checker for the exception unit ports
`timescale 1ns/10ps
module ctx_exc_props (
    // clock and reset
    input wire        CORE_CLK,
    input wire        SRST,
    // requests and decoder
    input wire        NMI_REQ,
    input wire        DEC_VALID,
    input wire        DEC_IN_SLOT,
    input wire        DEC_AFTER_SYSREG,
    input wire        DEC_UNDEF,
    input wire        DEC_PC_WRITE,
    input wire        DEC_TRAP,
    input wire [31:0] DEC_PC,
    input wire [31:0] DEC_NEXT_PC,
    input wire [31:0] DEC_SLOT_TARGET,
    // exception sequence
    input wire        EXC_BUSY,
    input wire        STK_WR,
    input wire [31:0] STK_DATA,
    input wire        VEC_RD,
    input wire        VEC_ACK,
    input wire [31:0] VEC_DATA,
    input wire        JUMP,
    input wire [31:0] JUMP_PC
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    wire go   = DEC_VALID && !EXC_BUSY;
    wire bad  = DEC_IN_SLOT && (DEC_UNDEF || DEC_PC_WRITE || DEC_TRAP);
    wire trap = go && DEC_TRAP && !DEC_IN_SLOT && !DEC_UNDEF;
    sequence s_stack;
        EXC_BUSY ##1 STK_WR ##1 STK_WR ##1 VEC_RD;
    endsequence
    property p_trap_seq;
        trap |=> s_stack;
    endproperty
    property p_trap_pc;
        trap |-> ##3 STK_DATA == $past(DEC_NEXT_PC, 3);
    endproperty
    property p_slot_seq;
        go && bad |=> s_stack;
    endproperty
    property p_slot_pc;
        go && bad |-> ##3 STK_DATA == $past(DEC_SLOT_TARGET, 3);
    endproperty
    property p_gen_pc;
        go && !DEC_IN_SLOT && DEC_UNDEF
            |-> ##3 STK_DATA == $past(DEC_PC, 3);
    endproperty
    property p_block;
        go && (DEC_IN_SLOT || DEC_AFTER_SYSREG) && !bad && !DEC_UNDEF
            && !DEC_TRAP |=> !EXC_BUSY;
    endproperty
    property p_nmi;
        go && $past(NMI_REQ) && !DEC_IN_SLOT && !DEC_AFTER_SYSREG
            |=> EXC_BUSY;
    endproperty
    property p_jump;
        EXC_BUSY && VEC_ACK
            |=> JUMP && !EXC_BUSY && JUMP_PC == $past(VEC_DATA);
    endproperty
    a_trap_seq: assert property (p_trap_seq) else $error("trap seq");
    a_trap_pc: assert property (p_trap_pc) else $error("trap pc");
    a_slot_seq: assert property (p_slot_seq) else $error("slot seq");
    a_slot_pc: assert property (p_slot_pc) else $error("slot pc");
    a_gen_pc: assert property (p_gen_pc) else $error("illegal pc");
    a_block: assert property (p_block) else $error("blocked taken");
    a_nmi: assert property (p_nmi) else $error("nmi refused");
    a_jump: assert property (p_jump) else $error("jump wrong");
endmodule
bind ctx_exception_unit ctx_exc_props u_props (
    .CORE_CLK(CORE_CLK), .SRST(SRST), .NMI_REQ(NMI_REQ),
    .DEC_VALID(DEC_VALID), .DEC_IN_SLOT(DEC_IN_SLOT),
    .DEC_AFTER_SYSREG(DEC_AFTER_SYSREG), .DEC_UNDEF(DEC_UNDEF),
    .DEC_PC_WRITE(DEC_PC_WRITE), .DEC_TRAP(DEC_TRAP), .DEC_PC(DEC_PC),
    .DEC_NEXT_PC(DEC_NEXT_PC), .DEC_SLOT_TARGET(DEC_SLOT_TARGET),
    .EXC_BUSY(EXC_BUSY), .STK_WR(STK_WR), .STK_DATA(STK_DATA),
    .VEC_RD(VEC_RD), .VEC_ACK(VEC_ACK), .VEC_DATA(VEC_DATA),
    .JUMP(JUMP), .JUMP_PC(JUMP_PC));

// *** ctx_vec_model.sv ***
// vector table memory answering the unit's fetches
`timescale 1ns/10ps
module ctx_vec_model (
    // clock
    input  wire        clk,
    // vector fetch
    input  wire        vec_rd,
    input  wire [31:0] vec_addr,
    output reg         vec_ack,
    output reg  [31:0] vec_data
);
    reg [31:0] addr_reg;
    reg [2:0]  wait_reg;
    reg        slow_reg;
    initial begin
        vec_ack = 1'b0;
        vec_data = 32'h0000_0000;
        wait_reg = 3'h0;
        slow_reg = 1'b0;
    end
    always @(posedge clk) begin
        vec_ack <= 1'b0;
        // data churns when idle so a stale read cannot match
        vec_data <= vec_data + 32'h0000_1357;
        if (vec_rd) begin
            addr_reg <= vec_addr;
            wait_reg <= slow_reg ? 3'h4 : 3'h1;
            slow_reg <= !slow_reg;
        end else if (wait_reg == 3'h1) begin
            vec_ack <= 1'b1;
            vec_data <= ~addr_reg;
            wait_reg <= 3'h0;
        end else if (wait_reg != 3'h0) begin
            wait_reg <= wait_reg - 3'h1;
        end
    end
endmodule

// *** ctx_exception_unit_bench.sv ***
// self-checking bench for the exception unit
`timescale 1ns/10ps
`include "ctx_exc_map.vh"
module ctx_exception_unit_bench;
    reg         CORE_CLK, SRST, HSEL, HWRITE, NMI_REQ, BRK_REQ, DBG_REQ;
    reg         DEC_VALID, DEC_IN_SLOT, DEC_AFTER_SYSREG, DEC_UNDEF;
    reg         DEC_PC_WRITE, DEC_TRAP;
    reg  [1:0]  HTRANS;
    reg  [2:0]  HSIZE;
    reg  [3:0]  ENCODED_LEVEL_PINS, EXTERNAL_REQUEST_PINS;
    reg  [7:0]  DEC_TRAP_VEC, tv;
    reg  [28:0] PER_REQ;
    reg  [31:0] HADDR, HWDATA, DEC_PC, DEC_NEXT_PC, DEC_SLOT_TARGET, rdat;
    reg  [31:0] vbase_m, q[$];
    reg  [3:0]  mask_m;
    wire        HREADYOUT, HRESP, EXC_BUSY, STK_WR, VEC_RD, VEC_ACK, JUMP;
    wire [3:0]  SR_MASK;
    wire [31:0] HRDATA, STK_DATA, VEC_ADDR, VEC_DATA, JUMP_PC;
    integer     error_cnt, checks, seed, i;
    ctx_exception_unit dut_u (
        .CORE_CLK(CORE_CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .NMI_REQ(NMI_REQ), .BRK_REQ(BRK_REQ),
        .DBG_REQ(DBG_REQ), .ENCODED_LEVEL_PINS(ENCODED_LEVEL_PINS),
        .EXTERNAL_REQUEST_PINS(EXTERNAL_REQUEST_PINS), .PER_REQ(PER_REQ),
        .DEC_VALID(DEC_VALID), .DEC_IN_SLOT(DEC_IN_SLOT),
        .DEC_AFTER_SYSREG(DEC_AFTER_SYSREG), .DEC_UNDEF(DEC_UNDEF),
        .DEC_PC_WRITE(DEC_PC_WRITE), .DEC_TRAP(DEC_TRAP),
        .DEC_TRAP_VEC(DEC_TRAP_VEC), .DEC_PC(DEC_PC),
        .DEC_NEXT_PC(DEC_NEXT_PC), .DEC_SLOT_TARGET(DEC_SLOT_TARGET),
        .EXC_BUSY(EXC_BUSY), .STK_WR(STK_WR), .STK_DATA(STK_DATA),
        .VEC_RD(VEC_RD), .VEC_ADDR(VEC_ADDR), .VEC_ACK(VEC_ACK),
        .VEC_DATA(VEC_DATA), .JUMP(JUMP), .JUMP_PC(JUMP_PC),
        .SR_MASK(SR_MASK));
    ctx_vec_model vec_u (.clk(CORE_CLK), .vec_rd(VEC_RD), .vec_addr(VEC_ADDR),
        .vec_ack(VEC_ACK), .vec_data(VEC_DATA));
    always #4 CORE_CLK = ~CORE_CLK;
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("ERROR %0t: got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task bus(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge CORE_CLK);
            HSEL <= 1'b1;
            HTRANS <= 2'b10;
            HWRITE <= w;
            HADDR <= {24'h00_0000, a};
            @(posedge CORE_CLK);
            while (HREADYOUT !== 1'b1) @(posedge CORE_CLK);
            HTRANS <= 2'b00;
            HWDATA <= d;
            @(posedge CORE_CLK);
            while (HREADYOUT !== 1'b1) @(posedge CORE_CLK);
            rdat = HRDATA;
            chk({31'h0, HRESP}, 32'h0000_0000);
        end
    endtask
    task wst(input [3:0] m);
        begin
            bus(1'b1, `CTX_OFF_STATUS, {24'h00_0000, m, 4'h0});
            mask_m = m;
        end
    endtask
    // f = {slot, after sysreg, undef, pc write, trap}; k picks stacked pc
    task go(input [4:0] f, input [1:0] k, input tk, input [7:0] v,
            input [3:0] nm);
        reg [31:0] pc, va;
        reg        busy;
        integer    n;
        begin
            pc = $random(seed);
            @(posedge CORE_CLK);
            {DEC_IN_SLOT, DEC_AFTER_SYSREG, DEC_UNDEF} <= f[4:2];
            {DEC_PC_WRITE, DEC_TRAP} <= f[1:0];
            DEC_VALID <= 1'b1;
            NMI_REQ <= 1'b0;
            DEC_TRAP_VEC <= v;
            DEC_PC <= pc;
            DEC_NEXT_PC <= pc + 32'h0000_0002;
            DEC_SLOT_TARGET <= ~pc;
            @(posedge CORE_CLK);
            DEC_VALID <= 1'b0;
            if (tk) q.push_back({24'h00_0000, mask_m, 4'h0});
            if (tk)
                q.push_back(k == 0 ? pc : k == 1 ? pc + 32'h0000_0002 : ~pc);
            va = vbase_m + 4 * v;
            busy = 1'b0;
            for (n = 0; n < 12; n = n + 1) begin
                @(negedge CORE_CLK);
                if (EXC_BUSY === 1'b1) busy = 1'b1;
                if (STK_WR === 1'b1 && q.size() > 0)
                    chk(STK_DATA, q.pop_front());
                if (VEC_RD === 1'b1) chk(VEC_ADDR, va);
                if (JUMP === 1'b1) chk(JUMP_PC, ~va);
            end
            chk({31'h0, busy}, {31'h0, tk});
            if (tk) mask_m = nm;
            chk({28'h000_0000, SR_MASK}, {28'h000_0000, mask_m});
        end
    endtask
    task test_done;
        begin
            $display("error_cnt %0d checks %0d", error_cnt, checks);
            if (error_cnt == 0 && checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        #100000;
        error_cnt = error_cnt + 1;
        test_done;
    end
    initial begin
        seed = 43;
        error_cnt = 0;
        checks = 0;
        mask_m = 4'hF;
        vbase_m = 32'h0000_1000;
        CORE_CLK = 1'b0;
        SRST = 1'b1;
        {HSEL, HWRITE, HTRANS} = 4'h0;
        HSIZE = 3'b010;
        {NMI_REQ, BRK_REQ, DBG_REQ, DEC_VALID, DEC_IN_SLOT} = 5'h00;
        {DEC_AFTER_SYSREG, DEC_UNDEF, DEC_PC_WRITE, DEC_TRAP} = 4'h0;
        {ENCODED_LEVEL_PINS, EXTERNAL_REQUEST_PINS, DEC_TRAP_VEC} = 16'h0000;
        {HADDR, HWDATA, DEC_PC, DEC_NEXT_PC, DEC_SLOT_TARGET} = 160'h0;
        PER_REQ = 29'h0000_0000;
        repeat (6) @(posedge CORE_CLK);
        SRST <= 1'b0;
        bus(1'b0, `CTX_OFF_STATUS, 32'h0000_0000);
        chk(rdat, `CTX_RST_STATUS);
        bus(1'b0, 8'h20, 32'h0000_0000);
        chk(rdat, 32'h0000_0000);
        bus(1'b1, `CTX_OFF_VBASE, vbase_m);
        wst(4'h5);
        bus(1'b1, `CTX_OFF_PRI_C, 32'h0000_8000);
        EXTERNAL_REQUEST_PINS <= 4'h1;
        go(5'h00, 0, 1, `CTX_VEC_IRQ_BASE, 4'h8);
        go(5'h00, 0, 0, 8'h00, 4'h8);
        ENCODED_LEVEL_PINS <= 4'h9;
        go(5'h08, 0, 0, 8'h00, 4'h8);
        go(5'h10, 0, 0, 8'h00, 4'h8);
        go(5'h00, 0, 1, 8'h49, 4'h9);
        bus(1'b0, `CTX_OFF_STATUS, 32'h0000_0000);
        chk(rdat, 32'h0000_0090);
        ENCODED_LEVEL_PINS <= 4'h0;
        EXTERNAL_REQUEST_PINS <= 4'h0;
        NMI_REQ <= 1'b1;
        go(5'h00, 0, 1, `CTX_VEC_NMI, 4'hF);
        wst(4'hE);
        BRK_REQ <= 1'b1;
        DBG_REQ <= 1'b1;
        go(5'h00, 0, 1, `CTX_VEC_BRK, 4'hF);
        BRK_REQ <= 1'b0;
        wst(4'hE);
        go(5'h00, 0, 1, `CTX_VEC_DBG, 4'hF);
        DBG_REQ <= 1'b0;
        wst(4'h0);
        PER_REQ <= 29'h1FFF_FFFF;
        go(5'h00, 0, 0, 8'h00, 4'h0);
        bus(1'b1, `CTX_OFF_PRI_A, 32'h0000_00C0);
        go(5'h00, 0, 1, 8'h62, 4'hC);
        rdat = $random(seed);
        PER_REQ <= rdat[28:0] | 29'h0001_0000;
        bus(1'b1, `CTX_OFF_PRI_D, 32'h0000_D000);
        go(5'h00, 0, 1, 8'h70, 4'hD);
        PER_REQ <= 29'h0000_0000;
        wst(4'h0);
        for (i = 0; i < 3; i = i + 1) begin
            tv = $random(seed);
            go(5'h01, 1, 1, tv, 4'h0);
        end
        go(5'h14, 2, 1, `CTX_VEC_ILL_SLOT, 4'h0);
        go(5'h12, 2, 1, `CTX_VEC_ILL_SLOT, 4'h0);
        go(5'h11, 2, 1, `CTX_VEC_ILL_SLOT, 4'h0);
        go(5'h04, 0, 1, `CTX_VEC_ILL_GEN, 4'h0);
        test_done;
    end
endmodule
